// [pssc_pkg.sv]
package pssc_pkg;
	localparam int instr_width = 10;
	localparam int nibble_width = 4;
	localparam int port_width = 6;
	localparam logic [9:0] port_bit_set_op = 10'h015;
	localparam logic [9:0] compare_immediate_skip_op = 10'h025;
	localparam logic [9:0] compare_memory_skip_op = 10'h026;
	localparam logic [9:0] ext0_flag_skip_op = 10'h038;
	localparam logic [5:0] imm_prefix = 6'h07;
	localparam int imm_prefix_pos = 4;
	localparam int ext0_enable_bit = 0;
	localparam logic [3:0] port_index_max = 4'h5;
	localparam logic [5:0] port_reset = 6'h00;
	localparam logic ext0_flag_reset = 1'b0;

	typedef enum logic {
		pssc_fetch = 1'b0,
		pssc_second_word = 1'b1
	} pssc_state_t;
endpackage : pssc_pkg

// [pssc_core.sv]
`timescale 1ns/1ps
module pssc_core (
	input wire logic clk,
	input wire logic reset,
	input wire logic instr_valid,
	input wire logic [9:0] instr_word,
	input wire logic [3:0] accumulator,
	input wire logic [3:0] data_pointer_nibble,
	input wire logic [3:0] index_reg,
	input wire logic [3:0] interrupt_control_one,
	input wire logic ext0_request_set,
	output logic [5:0] port_out,
	output logic skip_next,
	output logic instr_done,
	output logic second_word_wait,
	output logic ext0_request_flag
);
	pssc_pkg::pssc_state_t state;
	pssc_pkg::pssc_state_t next_state;
	logic [5:0] next_port_out;
	logic next_skip_next;
	logic next_instr_done;
	logic next_ext0_request_flag;
	logic ext0_interrupt_enable;
	logic flag_clear;
	logic next_second_word_wait;

	assign ext0_interrupt_enable = interrupt_control_one[pssc_pkg::ext0_enable_bit];

	function automatic logic nibble_equal(input logic [3:0] a, input logic [3:0] b);
		nibble_equal = (a == b);
	endfunction : nibble_equal

	always_comb begin
		next_state = state;
		next_port_out = port_out;
		next_skip_next = 1'b0;
		next_instr_done = 1'b0;
		flag_clear = 1'b0;
		if (instr_valid) begin
			unique case (state)
				pssc_pkg::pssc_fetch: begin
					if (instr_word == pssc_pkg::port_bit_set_op) begin
						next_instr_done = 1'b1;
						// out-of-range index leaves the port alone
						if (index_reg <= pssc_pkg::port_index_max) begin
							next_port_out[index_reg[2:0]] = 1'b1;
						end
					end else if (instr_word == pssc_pkg::compare_immediate_skip_op) begin
						next_state = pssc_pkg::pssc_second_word;
					end else if (instr_word == pssc_pkg::compare_memory_skip_op) begin
						next_instr_done = 1'b1;
						next_skip_next = nibble_equal(accumulator, data_pointer_nibble);
					end else if (instr_word == pssc_pkg::ext0_flag_skip_op) begin
						next_instr_done = 1'b1;
						if (!ext0_interrupt_enable) begin
							next_skip_next = ext0_request_flag;
							flag_clear = ext0_request_flag;
						end
					end
				end
				pssc_pkg::pssc_second_word: begin
					next_state = pssc_pkg::pssc_fetch;
					next_instr_done = 1'b1;
					// a malformed second word never skips
					next_skip_next = (instr_word[9:pssc_pkg::imm_prefix_pos] == pssc_pkg::imm_prefix) &&
						nibble_equal(accumulator, instr_word[3:0]);
				end
			endcase
		end
	end

	// a new request in the clearing cycle must survive, so set wins
	always_comb begin
		next_ext0_request_flag = ext0_request_set | (ext0_request_flag & ~flag_clear);
	end

	// sequencing group: the wait output mirrors the state so callers need not decode it
	always_comb begin
		next_second_word_wait = (next_state == pssc_pkg::pssc_second_word);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= pssc_pkg::pssc_fetch;
			second_word_wait <= 1'b0;
		end else begin
			state <= next_state;
			second_word_wait <= next_second_word_wait;
		end
	end

	// port group: bits are only ever set, so a stray decode cannot clear a driven pin
	always_ff @(posedge clk) begin
		if (reset) begin
			port_out <= pssc_pkg::port_reset;
		end else begin
			port_out <= next_port_out;
		end
	end

	// result group: both pulses last exactly one cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			skip_next <= 1'b0;
			instr_done <= 1'b0;
		end else begin
			skip_next <= next_skip_next;
			instr_done <= next_instr_done;
		end
	end

	// flag group
	always_ff @(posedge clk) begin
		if (reset) begin
			ext0_request_flag <= pssc_pkg::ext0_flag_reset;
		end else begin
			ext0_request_flag <= next_ext0_request_flag;
		end
	end

	port_set_bit_a: assert property (@(posedge clk) disable iff (reset)
		(instr_valid && state == pssc_pkg::pssc_fetch && instr_word == pssc_pkg::port_bit_set_op &&
		index_reg <= pssc_pkg::port_index_max) |=> port_out[$past(index_reg[2:0])] && instr_done)
		else $error("port bit not set");

	imm_skip_a: assert property (@(posedge clk) disable iff (reset)
		(instr_valid && state == pssc_pkg::pssc_second_word && instr_word[9:4] == pssc_pkg::imm_prefix &&
		instr_word[3:0] == accumulator) |=> skip_next && instr_done)
		else $error("immediate compare missed skip");

	imm_prefix_a: assert property (@(posedge clk) disable iff (reset)
		(instr_valid && state == pssc_pkg::pssc_second_word && instr_word[9:4] != pssc_pkg::imm_prefix)
		|=> !skip_next)
		else $error("skip on bad second word");

	mem_compare_a: assert property (@(posedge clk) disable iff (reset)
		(instr_valid && state == pssc_pkg::pssc_fetch && instr_word == pssc_pkg::compare_memory_skip_op)
		|=> instr_done && skip_next == ($past(accumulator) == $past(data_pointer_nibble)))
		else $error("memory compare wrong");

	flag_test_a: assert property (@(posedge clk) disable iff (reset)
		(instr_valid && state == pssc_pkg::pssc_fetch && instr_word == pssc_pkg::ext0_flag_skip_op &&
		!ext0_interrupt_enable && ext0_request_flag && !ext0_request_set) |=> skip_next && !ext0_request_flag)
		else $error("flag test did not skip and clear");

	flag_nop_a: assert property (@(posedge clk) disable iff (reset)
		(instr_valid && state == pssc_pkg::pssc_fetch && instr_word == pssc_pkg::ext0_flag_skip_op &&
		ext0_interrupt_enable && !ext0_request_set) |=> !skip_next && ext0_request_flag == $past(ext0_request_flag))
		else $error("flag test acted while enabled");

	port_range_a: assert property (@(posedge clk) disable iff (reset)
		(instr_valid && state == pssc_pkg::pssc_fetch && instr_word == pssc_pkg::port_bit_set_op &&
		index_reg > pssc_pkg::port_index_max) |=> $stable(port_out))
		else $error("port changed on bad index");

	flag_set_wins_a: assert property (@(posedge clk) disable iff (reset)
		ext0_request_set |=> ext0_request_flag)
		else $error("request lost");

	port_one_bit_a: assert property (@(posedge clk) disable iff (reset)
		(instr_valid && state == pssc_pkg::pssc_fetch && instr_word == pssc_pkg::port_bit_set_op &&
		index_reg <= pssc_pkg::port_index_max) |=> port_out == ($past(port_out) | (6'h01 << $past(index_reg))))
		else $error("port bits other than the indexed one changed");

	port_only_rises_a: assert property (@(posedge clk) disable iff (reset)
		1'b1 |=> ($past(port_out) & ~port_out) == 6'h00)
		else $error("port bit cleared");

	port_idle_a: assert property (@(posedge clk) disable iff (reset)
		!(instr_valid && state == pssc_pkg::pssc_fetch && instr_word == pssc_pkg::port_bit_set_op)
		|=> $stable(port_out))
		else $error("port changed without a set");

	imm_wait_a: assert property (@(posedge clk) disable iff (reset)
		(instr_valid && state == pssc_pkg::pssc_fetch && instr_word == pssc_pkg::compare_immediate_skip_op)
		|=> second_word_wait && !instr_done && !skip_next)
		else $error("first word did not wait for the second");

	second_hold_a: assert property (@(posedge clk) disable iff (reset)
		(!instr_valid && state == pssc_pkg::pssc_second_word)
		|=> second_word_wait && !instr_done && !skip_next)
		else $error("wait for the second word dropped");

	imm_miss_a: assert property (@(posedge clk) disable iff (reset)
		(instr_valid && state == pssc_pkg::pssc_second_word && instr_word[3:0] != accumulator)
		|=> !skip_next && instr_done && !second_word_wait)
		else $error("immediate compare skipped on mismatch");

	flag_empty_a: assert property (@(posedge clk) disable iff (reset)
		(instr_valid && state == pssc_pkg::pssc_fetch && instr_word == pssc_pkg::ext0_flag_skip_op &&
		!ext0_request_flag) |=> !skip_next && instr_done)
		else $error("flag test skipped on a clear flag");

	// only a set pulse or a test with the enable low may move the flag
	flag_hold_a: assert property (@(posedge clk) disable iff (reset)
		(!ext0_request_set && !(instr_valid && state == pssc_pkg::pssc_fetch &&
		instr_word == pssc_pkg::ext0_flag_skip_op && !ext0_interrupt_enable))
		|=> ext0_request_flag == $past(ext0_request_flag))
		else $error("flag moved without a set or a test");

	other_word_a: assert property (@(posedge clk) disable iff (reset)
		(instr_valid && state == pssc_pkg::pssc_fetch && instr_word != pssc_pkg::port_bit_set_op &&
		instr_word != pssc_pkg::compare_immediate_skip_op && instr_word != pssc_pkg::compare_memory_skip_op &&
		instr_word != pssc_pkg::ext0_flag_skip_op) |=> !instr_done && !skip_next && !second_word_wait)
		else $error("foreign word acted on");

	skip_done_a: assert property (@(posedge clk) disable iff (reset)
		skip_next |-> instr_done)
		else $error("skip without a finished instruction");

	// reset is synchronous, so the cleared values show one edge later
	reset_values_a: assert property (@(posedge clk)
		reset |=> port_out == pssc_pkg::port_reset && !skip_next && !instr_done && !second_word_wait &&
		ext0_request_flag == pssc_pkg::ext0_flag_reset)
		else $error("outputs not cleared by reset");
endmodule : pssc_core

// [port_set_and_skip_compare_ops_test.sv]
`timescale 1ns/1ps
module port_set_and_skip_compare_ops_test;
	logic clk = 1'h0;
	logic reset = 1'h1;
	logic instr_valid = 1'h0;
	logic [9:0] instr_word = 10'h000;
	logic [3:0] accumulator = 4'h0;
	logic [3:0] data_pointer_nibble = 4'h0;
	logic [3:0] index_reg = 4'h0;
	logic [3:0] interrupt_control_one = 4'h0;
	logic ext0_request_set = 1'h0;
	logic [5:0] port_out;
	logic skip_next, instr_done, second_word_wait, ext0_request_flag;
	logic [5:0] exp_port = 6'h00;
	logic exp_flag = 1'h0;
	logic [3:0] a, m, c;
	int fails = 0;
	int n_tests = 0;
	int seed = 46406;
	always #10 clk = ~clk;
	pssc_core pssc_core_i (.clk(clk), .reset(reset), .instr_valid(instr_valid), .instr_word(instr_word),
		.accumulator(accumulator), .data_pointer_nibble(data_pointer_nibble), .index_reg(index_reg),
		.interrupt_control_one(interrupt_control_one), .ext0_request_set(ext0_request_set), .port_out(port_out),
		.skip_next(skip_next), .instr_done(instr_done), .second_word_wait(second_word_wait),
		.ext0_request_flag(ext0_request_flag));
	function automatic logic [5:0] port_mask(input logic [3:0] idx);
		return (idx <= 4'h5) ? (6'h01 << idx) : 6'h00;
	endfunction : port_mask
	task check(input string name, input logic [5:0] seen, input logic [5:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task give_verdict;
		if (fails == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : give_verdict
	// one idle cycle between words keeps every input change clear of the taking edge
	task issue(input logic [9:0] w, input logic [3:0] acc, input logic [3:0] mem, input logic [3:0] idx,
		input logic [3:0] ctl);
		@(posedge clk);
		instr_valid <= 1'h1;
		instr_word <= w;
		accumulator <= acc;
		data_pointer_nibble <= mem;
		index_reg <= idx;
		interrupt_control_one <= ctl;
		@(posedge clk);
		instr_valid <= 1'h0;
		#1;
	endtask : issue
	initial begin
		#200000;
		fails++;
		give_verdict;
	end
	initial begin
		repeat (10) @(posedge clk);
		reset <= 1'h0;
		// words outside the group must do nothing, seen on a still clear port
		for (int i = 0; i < 8; i++) begin
			issue(10'($random(seed)) | 10'h040, 4'($random(seed)), 4'h0, 4'($random(seed)), 4'h0);
			check("foreign_word", {3'h0, skip_next, second_word_wait, instr_done}, 6'h00);
			check("foreign_port", port_out, exp_port);
		end
		// out-of-range indexes first, so a stray set shows on a clear port
		for (int i = 15; i >= 0; i--) begin
			issue(pssc_pkg::port_bit_set_op, 4'h0, 4'h0, i[3:0], 4'h0);
			exp_port = exp_port | port_mask(i[3:0]);
			check("port_out", port_out, exp_port);
			check("instr_done", {5'h00, instr_done}, 6'h01);
		end
		for (int i = 0; i < 24; i++) begin
			a = 4'($random(seed));
			m = (i % 3 == 0) ? a : 4'($random(seed));
			issue(pssc_pkg::compare_memory_skip_op, a, m, 4'h0, 4'h0);
			check("skip_mem", {4'h0, skip_next, instr_done}, {4'h0, a == m, 1'h1});
			issue(pssc_pkg::compare_immediate_skip_op, a, 4'h0, 4'h0, 4'h0);
			check("second_word_wait", {5'h00, second_word_wait}, 6'h01);
			check("early_done", {5'h00, instr_done}, 6'h00);
			issue({pssc_pkg::imm_prefix ^ {5'h00, i % 4 == 3}, m}, a, 4'h0, 4'h0, 4'h0);
			check("skip_imm", {5'h00, skip_next}, {5'h00, a == m && i % 4 != 3});
			check("wait_end", {4'h0, second_word_wait, instr_done}, 6'h01);
		end
		for (int i = 0; i < 12; i++) begin
			c = {3'($random(seed)), i[1]};
			if (i[0]) begin
				@(posedge clk);
				ext0_request_set <= 1'h1;
				@(posedge clk);
				ext0_request_set <= 1'h0;
				exp_flag = 1'h1;
			end
			issue(pssc_pkg::ext0_flag_skip_op, 4'h0, 4'h0, 4'h0, c);
			check("skip_flag", {4'h0, skip_next, instr_done}, {4'h0, exp_flag & ~c[0], 1'h1});
			exp_flag = exp_flag & c[0];
			check("ext0_request_flag", {5'h00, ext0_request_flag}, {5'h00, exp_flag});
		end
		// a new request in the clearing cycle must survive the test
		@(posedge clk);
		ext0_request_set <= 1'h1;
		@(posedge clk);
		instr_valid <= 1'h1;
		instr_word <= pssc_pkg::ext0_flag_skip_op;
		interrupt_control_one <= 4'h0;
		@(posedge clk);
		instr_valid <= 1'h0;
		ext0_request_set <= 1'h0;
		#1;
		check("skip_set_wins", {4'h0, skip_next, instr_done}, 6'h03);
		check("flag_set_wins", {5'h00, ext0_request_flag}, 6'h01);
		give_verdict;
	end
endmodule : port_set_and_skip_compare_ops_test
